// file: core/rhs_regs.svh
`ifndef RHS_REGS_SVH
`define RHS_REGS_SVH

// working register file geometry
`define RHS_WREG_COUNT     16
`define RHS_WREG_SEL_W     4
`define RHS_ADDR_W         16
// data-space byte address of working register 0; each takes two bytes
`define RHS_WREG_MAP_BASE  16'h0000
`define RHS_WREG_MAP_STEP  16'h0002
// stall length in instruction cycles
`define RHS_STALL_CYCLES   2'h1

`endif

// file: core/rhs_pkg.sv
package rhs_pkg;

  // addressing mode of one operand as seen by the hazard logic
  typedef enum logic [1:0] {
    RHS_MODE_NONE,
    RHS_MODE_DIRECT,
    RHS_MODE_IND,
    RHS_MODE_IND_MOD
  } rhs_mode_t;

endpackage

// file: core/rhs_alias_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "rhs_regs.svh"

// flags a destination address that lands on the mapped working register
module rhs_alias_match
  import rhs_pkg::*;
(
  input  wire logic [`RHS_ADDR_W-1:0]    i_addr,
  input  wire logic [`RHS_WREG_SEL_W-1:0] i_sel,
  output logic                           o_hit
);

  logic [`RHS_WREG_COUNT-1:0] hit_vec;

  // one comparator per mapped register, then pick the selected one
  genvar g;
  generate
    for (g = 0; g < `RHS_WREG_COUNT; g = g + 1) begin : g_map
      localparam logic [`RHS_ADDR_W-1:0] MAP_ADDR =
        `RHS_WREG_MAP_BASE + `RHS_WREG_MAP_STEP * 16'(g);
      // word compare; byte writes to the odd half still alias
      assign hit_vec[g] = (i_addr[`RHS_ADDR_W-1:1] ==
                           MAP_ADDR[`RHS_ADDR_W-1:1]);
    end
  endgenerate

  assign o_hit = hit_vec[i_sel];

endmodule
`default_nettype wire

// file: core/rhs_stall_unit.sv
//
// Functional notes
// - address generation and access take one cycle each
// - compare current destination with prefetched source register
// - no stall when destination leaves register unchanged
// - no stall when source computes no address
// - otherwise insert exactly one stall cycle
// - direct write then direct read: no stall
// - direct write then indirect read: stall
// - plain indirect write, no alias: no stall
// - indirect write aliasing register, indirect read: stall
// - modified indirect write then direct read: no stall
// - modified indirect write then indirect read: stall
// - stall: write completes, no access, no fetch, no increment
// - stall precedes the following instruction's execution
// - repeat loop compares same instruction against itself
`timescale 1ns/1ps
`default_nettype none
`include "rhs_regs.svh"

module rhs_stall_unit
  import rhs_pkg::*;
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_b,
  // one pulse per instruction cycle boundary from the sequencer
  input  wire logic                       i_cyc_adv,
  // executing instruction destination
  input  wire logic                       i_dst_valid,
  input  wire logic [`RHS_WREG_SEL_W-1:0] i_dst_wreg,
  input  wire rhs_mode_t                  i_dst_mode,
  input  wire logic [`RHS_ADDR_W-1:0]     i_dst_effective_address,
  // prefetched instruction source
  input  wire logic                       i_src_valid,
  input  wire logic [`RHS_WREG_SEL_W-1:0] i_src_wreg,
  input  wire rhs_mode_t                  i_src_mode,
  // single-instruction repeat loop active
  input  wire logic                       i_repeat_active,
  // stall outputs
  output logic                            o_stall,
  output logic                            o_data_access_en,
  output logic                            o_pc_inc_en,
  output logic                            o_fetch_en,
  output logic                            o_wb_en,
  output logic                            o_stall_owner_next
);

  ////////////////////////////////////////////////////////////////////////
  // hazard classification

  logic      alias_hit;
  logic      same_reg;
  logic      dst_changes_reg;
  logic      src_uses_ea;
  logic      hazard;
  logic [`RHS_WREG_SEL_W-1:0] src_sel;
  rhs_mode_t src_mode;

  // in a repeat loop the prefetch slot holds the same instruction
  always_comb begin
    src_sel  = i_src_wreg;
    src_mode = i_src_mode;
    if (i_repeat_active) begin
      src_sel  = i_src_wreg;
      src_mode = i_src_mode;
    end
  end

  rhs_alias_match u_alias (
    .i_addr (i_dst_effective_address),
    .i_sel  (i_dst_wreg),
    .o_hit  (alias_hit)
  );

  // register identity check across the instruction boundary
  assign same_reg = i_dst_valid && i_src_valid &&
                    (i_dst_wreg == src_sel);

  // does the destination write alter the register contents?
  always_comb begin
    dst_changes_reg = 1'b0;
    case (i_dst_mode)
      RHS_MODE_DIRECT:  dst_changes_reg = 1'b1;
      RHS_MODE_IND:     dst_changes_reg = alias_hit;
      RHS_MODE_IND_MOD: dst_changes_reg = 1'b1;
      default:          dst_changes_reg = 1'b0;
    endcase
  end

  // only address-forming reads need the fresh value
  always_comb begin
    src_uses_ea = 1'b0;
    case (src_mode)
      RHS_MODE_IND:     src_uses_ea = 1'b1;
      RHS_MODE_IND_MOD: src_uses_ea = 1'b1;
      default:          src_uses_ea = 1'b0;
    endcase
  end

  // both exemptions must fail to stall
  assign hazard = same_reg && dst_changes_reg && src_uses_ea;

  ////////////////////////////////////////////////////////////////////////
  // stall sequencing

  typedef enum logic {
    RHS_ST_RUN,
    RHS_ST_STALL
  } rhs_state_t;

  rhs_state_t state_q;
  rhs_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // check sampled at each boundary outside a stall; stall lasts one instruction cycle
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      RHS_ST_RUN: begin
        if (i_cyc_adv && hazard) begin
          state_d = RHS_ST_STALL;
          cnt_d   = `RHS_STALL_CYCLES;
        end
      end
      RHS_ST_STALL: begin
        if (i_cyc_adv) begin
          cnt_d = cnt_q - 2'h1;
          if (cnt_q == 2'h1) begin
            state_d = RHS_ST_RUN;
          end
        end
      end
      default: state_d = RHS_ST_RUN;
    endcase
  end

  // outputs registered so they line up with the stalled cycle
  logic stall_d;
  assign stall_d = (state_d == RHS_ST_STALL);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_q            <= RHS_ST_RUN;
      cnt_q              <= 2'h0;
      o_stall            <= 1'b0;
      o_data_access_en   <= 1'b1;
      o_pc_inc_en        <= 1'b1;
      o_fetch_en         <= 1'b1;
      o_wb_en            <= 1'b1;
      o_stall_owner_next <= 1'b0;
    end else begin
      state_q            <= state_d;
      cnt_q              <= cnt_d;
      o_stall            <= stall_d;
      o_data_access_en   <= !stall_d;
      o_pc_inc_en        <= !stall_d;
      o_fetch_en         <= !stall_d;
      o_wb_en            <= 1'b1;     // pending write always finishes
      o_stall_owner_next <= stall_d;
    end
  end

endmodule
`default_nettype wire

// file: verif/rhs_stall_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rhs_regs.svh"
module rhs_stall_monitor
  import rhs_pkg::*;
(
  input wire logic                       i_sys_clk,
  input wire logic                       i_rst_b,
  input wire logic                       i_cyc_adv,
  input wire logic                       i_dst_valid,
  input wire logic [`RHS_WREG_SEL_W-1:0] i_dst_wreg,
  input wire rhs_mode_t                  i_dst_mode,
  input wire logic [`RHS_ADDR_W-1:0]     i_dst_effective_address,
  input wire logic                       i_src_valid,
  input wire logic [`RHS_WREG_SEL_W-1:0] i_src_wreg,
  input wire rhs_mode_t                  i_src_mode,
  input wire logic                       o_stall,
  input wire logic                       o_data_access_en,
  input wire logic                       o_pc_inc_en,
  input wire logic                       o_fetch_en,
  input wire logic                       o_wb_en,
  input wire logic                       o_stall_owner_next
);
  logic al, hz;
  // word compare: odd byte of a mapped register still aliases it
  assign al = i_dst_effective_address[15:1] == {11'h000, i_dst_wreg};
  // mode bit0: direct or modified write; bit1: source forms an address
  assign hz = i_dst_valid && i_src_valid && i_dst_wreg == i_src_wreg &&
              i_src_mode[1] &&
              (i_dst_mode[0] || (i_dst_mode == RHS_MODE_IND && al));
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_hit;
    i_cyc_adv && hz && !o_stall;
  endsequence
  a_stall_hit: assert property (s_hit |=> o_stall)
    else $error("hazard gave no stall");
  a_no_hazard: assert property (!o_stall && !(i_cyc_adv && hz) |=> !o_stall)
    else $error("stall without hazard");
  a_stall_one: assert property (o_stall && i_cyc_adv |=> !o_stall)
    else $error("stall longer than one cycle");
  a_stall_hold: assert property (o_stall && !i_cyc_adv |=> o_stall)
    else $error("stall dropped mid cycle");
  a_rise_cause: assert property ($rose(o_stall) |-> $past(hz))
    else $error("stall rose without cause");
  a_fetch_off: assert property (o_stall != (o_fetch_en && o_pc_inc_en))
    else $error("fetch or pc wrong");
  a_data_off: assert property (o_stall == !o_data_access_en)
    else $error("data access wrong");
  a_write_on: assert property (o_wb_en)
    else $error("pending write blocked");
  a_owner_next: assert property (o_stall_owner_next == o_stall)
    else $error("stall owner wrong");
endmodule
bind rhs_stall_unit rhs_stall_monitor u_mon (.*);
`default_nettype wire

// file: verif/rhs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rhs_far_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_fetch_en,
  input  wire logic [29:0] i_nxt,
  output logic      [29:0] o_ins
);
  logic [29:0] ins_d;
  // inhibited fetch loads zero into the prefetch slot, leaving it empty
  always_comb ins_d = i_fetch_en ? i_nxt : '0;
  always_ff @(posedge i_sys_clk) o_ins <= i_rst_b ? ins_d : '0;
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %b exp %b", $time, a, b); end end
module tb;
  import rhs_pkg::*;
  logic clk = 0, rst_b = 0, adv = 0, rep = 0;
  logic [29:0] nxt = '0, ins;
  logic st, dae, pce, fe, wbe, own;
  int n_fail = 0, compares = 0, seed = 32'h9D59;
  always #12.5 clk = ~clk;
  rhs_far_model far (.i_sys_clk(clk), .i_rst_b(rst_b), .i_fetch_en(fe),
    .i_nxt(nxt), .o_ins(ins));
  rhs_stall_unit dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cyc_adv(adv),
    .i_dst_valid(ins[29]), .i_dst_wreg(ins[28:25]),
    .i_dst_mode(rhs_mode_t'(ins[24:23])),
    .i_dst_effective_address(ins[22:7]), .i_src_valid(ins[6]),
    .i_src_wreg(ins[5:2]), .i_src_mode(rhs_mode_t'(ins[1:0])),
    .i_repeat_active(rep), .o_stall(st), .o_data_access_en(dae),
    .o_pc_inc_en(pce), .o_fetch_en(fe), .o_wb_en(wbe),
    .o_stall_owner_next(own));
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one instruction pair; hold keeps the cycle boundary off for a clock
  task automatic issue(int dv, sv, dm, sm, dw, sw, al, hold);
    int e;
    logic [15:0] ea;
    e = dv && sv && dw == sw && sm >= 2 && (dm % 2 || (dm == 2 && al));
    ea = (al ? 16'h0000 : 16'h0800) + 16'(dw * 2 + hold);
    @(posedge clk);
    nxt <= {dv[0], dw[3:0], dm[1:0], ea, sv[0], sw[3:0], sm[1:0]};
    adv <= 1'b1;
    rep <= $random(seed);
    @(posedge clk);
    nxt <= '0;
    @(posedge clk);
    adv <= !hold[0];
    #1 `CHK(st, e[0])
    `CHK({fe, pce, dae, wbe, own}, {{3{!e[0]}}, 1'b1, e[0]})
    @(posedge clk);
    adv <= 1'b1;
    #1 `CHK(st, e[0] && hold[0])
    @(posedge clk);
    #1 `CHK(st, 1'b0)
  endtask
  // hang guard well beyond the planned traffic
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // every mode pairing on one register, aliased or not, held or not
    for (int k = 0; k < 64; k++)
      issue(1, 1, k % 4, k / 4 % 4, 2, 2, k / 16 % 2, k / 32);
    for (int k = 0; k < 200; k++)
      issue($random(seed) & 1, $random(seed) & 1, $random(seed) & 3,
        $random(seed) & 3, $random(seed) & 3, $random(seed) & 3,
        $random(seed) & 1, $random(seed) & 1);
    report_and_stop;
  end
endmodule
`default_nettype wire
